// ===== hw/gauge_pkg.sv
/*
 * Shared constants and carriers for the capacity learning and end-of-discharge logic.
 * Assumes a 50 MHz clock and one measurement tick carrying per-interval deltas.
 */
package gauge_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONFIG     = 8'h00;
    localparam logic [7:0] OFS_NEAR_FULL  = 8'h04;
    localparam logic [7:0] OFS_BATT_LOW   = 8'h08;
    localparam logic [7:0] OFS_LEARN_TEMP = 8'h0C;
    localparam logic [7:0] OFS_OVERLOAD   = 8'h10;
    localparam logic [7:0] OFS_DESIGN_CAP = 8'h14;
    localparam logic [7:0] OFS_THR_WORD0  = 8'h18;
    localparam logic [7:0] OFS_THR_WORD1  = 8'h1C;
    localparam logic [7:0] OFS_THR_WORD2  = 8'h20;
    localparam logic [7:0] OFS_COLD_TC    = 8'h24;
    localparam logic [7:0] OFS_FULL       = 8'h28;
    localparam logic [7:0] OFS_LEFT       = 8'h2C;
    localparam logic [7:0] OFS_TALLY      = 8'h30;
    localparam logic [7:0] OFS_PACK_STAT  = 8'h34;
    localparam logic [7:0] OFS_THR_NOW    = 8'h38;

    // ------------------------------------------------------------------
    // Configuration bits
    // ------------------------------------------------------------------
    localparam int unsigned CFG_CELL_SEL  = 0;
    localparam int unsigned CFG_COMP_EN   = 1;
    localparam int unsigned CFG_FIXED_LOW = 2;
    localparam int unsigned CFG_TRIM_EN   = 5;

    // ------------------------------------------------------------------
    // Limits (mAh, mV, 0.1 K)
    // ------------------------------------------------------------------
    localparam logic [15:0] LOAD_LIMIT_MAH = 16'h0100;
    localparam logic [15:0] VOLT_MARGIN_MV = 16'h0100;
    localparam logic [15:0] CHG_VALID_MAH  = 16'h000A;
    localparam logic [15:0] FULL_MAX_DEC   = 16'h0100;
    localparam logic [15:0] FULL_MAX_INC   = 16'h0200;
    localparam logic [15:0] PCT_MID_NUM    = 16'h0003;
    localparam logic [15:0] PCT_DEN        = 16'h0064;
    localparam logic [15:0] COLD_TEMP_DK   = 16'h0B90;
    localparam int unsigned TRIM_SHIFT     = 7;
    localparam int unsigned RATE_SHIFT     = 5;
    localparam int unsigned FRAC_SHIFT     = 8;
    localparam int unsigned IR_SHIFT       = 12;
    localparam int unsigned TC_SHIFT       = 4;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0]        pack_mv;
        logic [15:0]        cell_min_mv;
        logic signed [15:0] current_ma;
        logic [15:0]        temp_dk;
        logic [7:0]         dis_mah;
        logic [7:0]         load_mah;
        logic [7:0]         chg_mah;
        logic               midrange_corr;
    } meas_s;

    typedef struct packed {
        logic [15:0] low;
        logic [15:0] mid;
        logic [15:0] high;
    } thr_s;

endpackage

// ===== hw/edv_threshold_calc.sv
/*
 * Computes the three end-of-discharge voltage thresholds, fixed or compensated.
 * Assumes stable configuration words; purely combinational, result read per tick.
 */
`timescale 1ns/1ps
module edv_threshold_calc
    import gauge_pkg::*;
(
    input  wire logic        comp_en_i,
    input  wire logic        fixed_low_i,
    input  wire logic [15:0] word0_i,
    input  wire logic [15:0] word1_i,
    input  wire logic [15:0] word2_i,
    input  wire logic [7:0]  cold_tc_i,
    input  wire logic [15:0] load_ma_i,
    input  wire logic [15:0] temp_dk_i,
    output gauge_pkg::thr_s  thr_o
);
    import gauge_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
        sat_sub = (a > b) ? a - b : 16'h0000;
    endfunction

    logic [31:0] ir_full;
    logic [15:0] ir_drop;
    logic [23:0] cold_full;
    logic [15:0] drop;

    // Simplified model: base voltage less capacity term less load term,
    // load term grows when cold. Good enough for trend, not for absolute accuracy.
    always_comb begin
        ir_full   = load_ma_i * word2_i;
        ir_drop   = ir_full[IR_SHIFT +: 16];
        cold_full = ir_drop * cold_tc_i;
        drop      = (temp_dk_i < COLD_TEMP_DK) ? ir_drop + cold_full[TC_SHIFT +: 16] : ir_drop;
        if (comp_en_i) begin
            thr_o.low  = fixed_low_i ? word0_i : sat_sub(sat_sub(word0_i, word1_i), drop);
            thr_o.mid  = sat_sub(sat_sub(word0_i, word1_i >> 1), drop);
            thr_o.high = sat_sub(sat_sub(word0_i, word1_i >> 2), drop);
        end else begin
            thr_o.low  = word0_i;
            thr_o.mid  = word1_i;
            thr_o.high = word2_i;
        end
    end

endmodule

// ===== hw/capacity_learning_eod_logic.sv
/*
 * Capacity learning, discharge tally and end-of-discharge correction, with an AHB-Lite register slave.
 * Assumes one meas_valid_i pulse per measurement interval carrying that interval's deltas.
 */
// Function
// - Tally grows in discharge by measured discharge plus load and self-discharge.
// - At discharge start tally loads full minus remaining if within near-full window.
// - Trim enable subtracts one 128th of full capacity from starting tally.
// - Tally stops counting when the high threshold is reached.
// - Qualified discharge sets full capacity to tally plus low-battery fraction share.
// - More than 256 mAh load and self-discharge disqualifies learning.
// - Temperature below learning low limit disqualifies learning.
// - High threshold voltage below threshold minus 256 mV disqualifies learning.
// - Any midrange correction during discharge disqualifies learning.
// - Current above 3C/32 or overload at threshold or low level disqualifies.
// - Uninterrupted 10 mAh charge during discharge disqualifies learning.
// - Learning flag sets at qualified start, clears on any disqualification.
// - Each full capacity update limited to minus 256 or plus 512 mAh.
// - Updated full capacity goes to nonvolatile store within four seconds.
// - Config bit selects pack voltage or lowest cell voltage for thresholds.
// - Compensation computes thresholds; fixed-lowest bit keeps lowest uncompensated.
// - Threshold detection suspended while current exceeds overload threshold.
// - Charge clears threshold flags; 10 mAh charge clears learning flag.
// - Thresholds pull remaining capacity down to 0%, 3%, low-battery fraction.
// - No threshold flags or adjustments while discharge current below C/32.
// - While learning, remaining capacity held at a level until its threshold.
// - Zero low-battery fraction disables lowest and middle corrections.
`timescale 1ns/1ps
module capacity_learning_eod_logic
    import gauge_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            reset_i,
    input  wire logic            hsel_i,
    input  wire logic [31:0]     haddr_i,
    input  wire logic [1:0]      htrans_i,
    input  wire logic            hwrite_i,
    input  wire logic [2:0]      hsize_i,
    input  wire logic [31:0]     hwdata_i,
    input  wire logic            hready_i,
    output logic      [31:0]     hrdata_o,
    output logic                 hreadyout_o,
    output logic                 hresp_o,
    input  wire logic            meas_valid_i,
    input  gauge_pkg::meas_s     meas_i,
    output logic                 nv_write_o,
    output logic      [15:0]     nv_data_o,
    output logic                 learning_valid_flag_o,
    output logic      [2:0]      edv_flags_o
);
    import gauge_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_COUNT,
        PH_STOP
    } phase_e;

    typedef struct packed {
        logic [7:0]  cfg;
        logic [15:0] near_full;
        logic [7:0]  batt_low;
        logic [15:0] learn_low_temp;
        logic [15:0] overload_ma;
        logic [15:0] design_cap;
        logic [15:0] word0;
        logic [15:0] word1;
        logic [15:0] word2;
        logic [7:0]  cold_tc;
        logic [15:0] full_charge_capacity;
        logic [15:0] remaining_capacity;
        logic [15:0] discharge_tally;
        logic [15:0] load_acc;
        logic [15:0] chg_run;
        logic        learning_valid_flag;
        logic [2:0]  edv_flags;
        logic        low_seen;
        logic        was_dis;
        phase_e      phase;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
        logic        nv_wr;
        logic [15:0] nv_data;
    } st_s;

    st_s  s_ff;
    st_s  nxt_s;
    thr_s thr;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
        sat_sub = (a > b) ? a - b : 16'h0000;
    endfunction

    function automatic logic [15:0] frac_of(input logic [15:0] cap, input logic [7:0] f);
        logic [23:0] p;
        p       = cap * f;
        frac_of = p[FRAC_SHIFT +: 16];
    endfunction

    function automatic logic [31:0] reg_read(input st_s s, input logic [7:0] a, input thr_s t);
        reg_read = 32'h0000_0000;
        case (a)
            OFS_CONFIG:     reg_read = {24'h00_0000, s.cfg};
            OFS_NEAR_FULL:  reg_read = {16'h0000, s.near_full};
            OFS_BATT_LOW:   reg_read = {24'h00_0000, s.batt_low};
            OFS_LEARN_TEMP: reg_read = {16'h0000, s.learn_low_temp};
            OFS_OVERLOAD:   reg_read = {16'h0000, s.overload_ma};
            OFS_DESIGN_CAP: reg_read = {16'h0000, s.design_cap};
            OFS_THR_WORD0:  reg_read = {16'h0000, s.word0};
            OFS_THR_WORD1:  reg_read = {16'h0000, s.word1};
            OFS_THR_WORD2:  reg_read = {16'h0000, s.word2};
            OFS_COLD_TC:    reg_read = {24'h00_0000, s.cold_tc};
            OFS_FULL:       reg_read = {16'h0000, s.full_charge_capacity};
            OFS_LEFT:       reg_read = {16'h0000, s.remaining_capacity};
            OFS_TALLY:      reg_read = {16'h0000, s.discharge_tally};
            OFS_PACK_STAT:  reg_read = {26'h000_0000, s.phase, s.edv_flags, s.learning_valid_flag};
            OFS_THR_NOW:    reg_read = {t.high, t.low};
            default:        reg_read = 32'h0000_0000;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Threshold computation
    // ------------------------------------------------------------------
    logic [15:0] i_abs;
    assign i_abs = meas_i.current_ma[15] ? 16'(-meas_i.current_ma) : 16'(meas_i.current_ma);

    edv_threshold_calc u_thr (
        .comp_en_i   (s_ff.cfg[CFG_COMP_EN]),
        .fixed_low_i (s_ff.cfg[CFG_FIXED_LOW]),
        .word0_i     (s_ff.word0),
        .word1_i     (s_ff.word1),
        .word2_i     (s_ff.word2),
        .cold_tc_i   (s_ff.cold_tc),
        .load_ma_i   (i_abs),
        .temp_dk_i   (meas_i.temp_dk),
        .thr_o       (thr)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic        dis;
        logic        chg;
        logic        ovl;
        logic        det_en;
        logic        q;
        logic [15:0] vsel;
        logic [15:0] c32;
        logic [15:0] c3_32;
        logic [15:0] low_lvl;
        logic [15:0] mid_lvl;
        logic [15:0] rc_n;
        logic [15:0] gap;
        logic [15:0] dec;
        logic [16:0] cand;
        logic [16:0] up_lim;
        logic [2:0]  hit;
        logic [2:0]  fresh;
        logic [31:0] mid_full;
        dis      = 1'b0;
        chg      = 1'b0;
        ovl      = 1'b0;
        det_en   = 1'b0;
        q        = s_ff.learning_valid_flag;
        vsel     = 16'h0000;
        c32      = s_ff.design_cap >> RATE_SHIFT;
        c3_32    = 16'(c32 * 16'h0003);
        low_lvl  = frac_of(s_ff.full_charge_capacity, s_ff.batt_low);
        mid_full = s_ff.full_charge_capacity * PCT_MID_NUM;
        mid_lvl  = 16'(mid_full / PCT_DEN);
        rc_n     = s_ff.remaining_capacity;
        gap      = 16'h0000;
        dec      = 16'h0000;
        cand     = 17'h0_0000;
        up_lim   = 17'h0_0000;
        hit      = 3'b000;
        fresh    = 3'b000;
        nxt_s        = s_ff;
        nxt_s.nv_wr  = 1'b0;

        // Bus: address phase captured, write lands in the data phase
        nxt_s.wr_pend = 1'b0;
        if (hsel_i && hready_i && htrans_i[1]) begin
            nxt_s.wr_pend = hwrite_i;
            nxt_s.wr_addr = haddr_i[7:0];
            if (!hwrite_i) begin
                nxt_s.rdata = reg_read(s_ff, haddr_i[7:0], thr);
            end
        end

        // Measurement tick
        if (meas_valid_i) begin
            dis  = meas_i.current_ma < 0;
            chg  = meas_i.current_ma > 0;
            vsel = s_ff.cfg[CFG_CELL_SEL] ? meas_i.cell_min_mv : meas_i.pack_mv;
            ovl  = i_abs > s_ff.overload_ma;
            det_en = dis && !ovl && (i_abs >= c32);

            // Remaining capacity follows charge and discharge
            dec  = dis ? 16'(meas_i.dis_mah + meas_i.load_mah) : {8'h00, meas_i.load_mah};
            rc_n = sat_sub(s_ff.remaining_capacity, dec);
            if (chg) begin
                cand = {1'b0, rc_n} + {9'h000, meas_i.chg_mah};
                rc_n = (cand > {1'b0, s_ff.full_charge_capacity}) ? s_ff.full_charge_capacity : cand[15:0];
            end

            // Hold at the pending level while learning
            if (s_ff.learning_valid_flag && dis) begin
                if (!s_ff.edv_flags[2] && s_ff.remaining_capacity >= low_lvl && rc_n < low_lvl) begin
                    rc_n = low_lvl;
                end else if (s_ff.edv_flags[2] && !s_ff.edv_flags[1] && s_ff.batt_low != 8'h00
                             && s_ff.remaining_capacity >= mid_lvl && rc_n < mid_lvl) begin
                    rc_n = mid_lvl;
                end
            end

            // Charge: flags drop at once, learning only after a solid 10 mAh
            if (chg) begin
                nxt_s.edv_flags = 3'b000;
                nxt_s.chg_run   = s_ff.chg_run + {8'h00, meas_i.chg_mah};
                if (nxt_s.chg_run >= CHG_VALID_MAH) begin
                    q           = 1'b0;
                    nxt_s.phase = PH_IDLE;
                end
            end else begin
                nxt_s.chg_run = 16'h0000;
            end

            // Start of discharge
            if (dis && !s_ff.was_dis && s_ff.phase != PH_COUNT) begin
                gap = sat_sub(s_ff.full_charge_capacity, s_ff.remaining_capacity);
                if (gap <= s_ff.near_full) begin
                    nxt_s.discharge_tally = s_ff.cfg[CFG_TRIM_EN]
                        ? sat_sub(gap, s_ff.full_charge_capacity >> TRIM_SHIFT) : gap;
                    q              = 1'b1;
                    nxt_s.phase    = PH_COUNT;
                    nxt_s.load_acc = 16'h0000;
                    nxt_s.low_seen = 1'b0;
                end
            end

            // Counting period
            if (s_ff.phase == PH_COUNT && dis) begin
                nxt_s.discharge_tally = nxt_s.discharge_tally + dec;
                nxt_s.load_acc        = s_ff.load_acc + {8'h00, meas_i.load_mah};
                if (nxt_s.load_acc > LOAD_LIMIT_MAH) begin
                    q = 1'b0;
                end
            end
            if (nxt_s.phase == PH_COUNT) begin
                if (meas_i.temp_dk < s_ff.learn_low_temp) begin
                    q = 1'b0;
                end
                if (meas_i.midrange_corr) begin
                    q = 1'b0;
                end
                if (!s_ff.low_seen && rc_n <= low_lvl) begin
                    nxt_s.low_seen = 1'b1;
                    if (i_abs > c3_32 || ovl) begin
                        q = 1'b0;
                    end
                end
            end

            // Threshold detection and corrections
            if (det_en) begin
                hit   = {vsel <= thr.high, vsel <= thr.mid, vsel <= thr.low};
                fresh = hit & ~s_ff.edv_flags;
                nxt_s.edv_flags = s_ff.edv_flags | hit;
                if (fresh[2] && rc_n > low_lvl) begin
                    rc_n = low_lvl;
                end
                if (fresh[1] && s_ff.batt_low != 8'h00 && rc_n > mid_lvl) begin
                    rc_n = mid_lvl;
                end
                if (fresh[0] && s_ff.batt_low != 8'h00) begin
                    rc_n = 16'h0000;
                end
                if (fresh[2] && s_ff.phase == PH_COUNT) begin
                    nxt_s.phase = PH_STOP;
                    if (vsel < sat_sub(thr.high, VOLT_MARGIN_MV)) begin
                        q = 1'b0;
                    end
                    if (i_abs > c3_32 || ovl) begin
                        q = 1'b0;
                    end
                    if (q) begin
                        cand   = {1'b0, nxt_s.discharge_tally} + {1'b0, low_lvl};
                        up_lim = {1'b0, s_ff.full_charge_capacity} + {1'b0, FULL_MAX_INC};
                        if (cand > up_lim) begin
                            cand = up_lim;
                        end else if (cand < {1'b0, sat_sub(s_ff.full_charge_capacity, FULL_MAX_DEC)}) begin
                            cand = {1'b0, sat_sub(s_ff.full_charge_capacity, FULL_MAX_DEC)};
                        end
                        nxt_s.full_charge_capacity = (cand[16]) ? 16'hFFFF : cand[15:0];
                        nxt_s.nv_wr                = 1'b1;
                        nxt_s.nv_data              = nxt_s.full_charge_capacity;
                    end
                end
            end

            nxt_s.remaining_capacity  = rc_n;
            nxt_s.learning_valid_flag = q;
            nxt_s.was_dis             = dis;
        end

        // Software writes win over the same-cycle tick for stored words
        if (s_ff.wr_pend) begin
            case (s_ff.wr_addr)
                OFS_CONFIG:     nxt_s.cfg                  = hwdata_i[7:0];
                OFS_NEAR_FULL:  nxt_s.near_full            = hwdata_i[15:0];
                OFS_BATT_LOW:   nxt_s.batt_low             = hwdata_i[7:0];
                OFS_LEARN_TEMP: nxt_s.learn_low_temp       = hwdata_i[15:0];
                OFS_OVERLOAD:   nxt_s.overload_ma          = hwdata_i[15:0];
                OFS_DESIGN_CAP: nxt_s.design_cap           = hwdata_i[15:0];
                OFS_THR_WORD0:  nxt_s.word0                = hwdata_i[15:0];
                OFS_THR_WORD1:  nxt_s.word1                = hwdata_i[15:0];
                OFS_THR_WORD2:  nxt_s.word2                = hwdata_i[15:0];
                OFS_COLD_TC:    nxt_s.cold_tc              = hwdata_i[7:0];
                OFS_FULL:       nxt_s.full_charge_capacity = hwdata_i[15:0];
                OFS_LEFT:       nxt_s.remaining_capacity   = hwdata_i[15:0];
                default:        nxt_s.cfg                  = nxt_s.cfg;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Zero wait states; every transfer answers OKAY
    assign hreadyout_o           = 1'b1;
    assign hresp_o               = 1'b0;
    assign hrdata_o              = s_ff.rdata;
    assign nv_write_o            = s_ff.nv_wr;
    assign nv_data_o             = s_ff.nv_data;
    assign learning_valid_flag_o = s_ff.learning_valid_flag;
    assign edv_flags_o           = s_ff.edv_flags;

endmodule

// ===== sim/nv_store_model.sv
/* Flash store model taking full capacity writes.
   Assumes nv_write_i pulses one cycle with the data beside it. */
`timescale 1ns/1ps
module nv_store_model (
    input  wire logic        clk_i,
    input  wire logic        nv_write_i,
    input  wire logic [15:0] nv_data_i,
    output logic      [15:0] stored_o,
    output logic      [7:0]  writes_o
);
    // ------------
    // Store
    // ------------
    initial begin
        stored_o = 16'h0000;
        writes_o = 8'h00;
    end
    always @(posedge clk_i) begin
        if (nv_write_i) begin
            stored_o <= nv_data_i;
            writes_o <= writes_o + 8'h01;
        end
    end
endmodule

// ===== sim/capacity_learning_eod_logic_properties.sv
/* Port checker for the learning and end-of-discharge block.
   Assumes one clock domain and a synchronous reset. */
`timescale 1ns/1ps
module capacity_learning_eod_logic_properties
    import gauge_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        meas_valid_i,
    input gauge_pkg::meas_s meas_i,
    input wire logic        nv_write_o,
    input wire logic [15:0] nv_data_o,
    input wire logic        learning_valid_flag_o,
    input wire logic [2:0]  edv_flags_o
);
    // ------------
    // Properties
    // ------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus wait or error");
    a_nv_single: assert property (nv_write_o |=> !nv_write_o) else $error("store pulse long");
    a_nv_after_tick: assert property (nv_write_o |-> $past(meas_valid_i)) else $error("store w/o tick");
    a_nv_data_held: assert property (!$stable(nv_data_o) |-> nv_write_o) else $error("data moved");
    a_flag_discharge: assert property ((edv_flags_o & ~$past(edv_flags_o)) != 3'b000 |->
        $past(meas_valid_i) && $past(meas_i.current_ma) < 0) else $error("flag not in discharge");
    a_charge_clears: assert property (meas_valid_i && meas_i.current_ma > 0 && meas_i.chg_mah != 8'h00
        |=> edv_flags_o == 3'b000) else $error("flags kept in charge");
    a_charge_disq: assert property (meas_valid_i && meas_i.current_ma > 0 && meas_i.chg_mah >= 8'h0A
        |=> !learning_valid_flag_o) else $error("learning kept in charge");
    a_mid_disq: assert property (meas_valid_i && meas_i.midrange_corr |=> !learning_valid_flag_o)
        else $error("learning kept on midrange");
    a_learn_start: assert property ($rose(learning_valid_flag_o) |-> $past(meas_valid_i) &&
        $past(meas_i.current_ma) < 0) else $error("learning not at discharge");
    cover property (nv_write_o);
    cover property ($rose(learning_valid_flag_o));
    cover property (edv_flags_o == 3'b111);
endmodule

// ===== sim/capacity_learning_eod_logic_tb.sv
/* Bench for the learning and end-of-discharge block.
   Assumes zero-wait AHB-Lite slave and one tick per interval. */
`timescale 1ns/1ps
module capacity_learning_eod_logic_tb;
    import gauge_pkg::*;
    logic        clk_i, reset_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, meas_valid_i, nv_write_o, lv;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic [1:0]  htrans_i;
    logic [15:0] nv_data_o, stored;
    logic [7:0]  writes;
    logic [2:0]  edv_flags_o;
    meas_s       meas_i;
    int          fails, checks, cycles;
    logic [7:0]  ca [10] = '{OFS_NEAR_FULL, OFS_BATT_LOW, OFS_LEARN_TEMP, OFS_OVERLOAD, OFS_DESIGN_CAP,
                             OFS_THR_WORD0, OFS_THR_WORD1, OFS_THR_WORD2, OFS_FULL, OFS_LEFT};
    logic [31:0] cd [10] = '{32'h64, 32'h0D, 32'hAAA, 32'h1000, 32'hC80, 32'hBB8, 32'hC1C, 32'hC80,
                             32'hBB8, 32'hB86};
    capacity_learning_eod_logic u_capacity_learning_eod_logic (.clk_i, .reset_i, .hsel_i, .haddr_i,
        .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
        .hresp_o, .meas_valid_i, .meas_i, .nv_write_o, .nv_data_o, .learning_valid_flag_o(lv), .edv_flags_o);
    nv_store_model u_nv_store_model (.clk_i, .nv_write_i(nv_write_o), .nv_data_i(nv_data_o),
        .stored_o(stored), .writes_o(writes));
    // ------------
    // Tasks
    // ------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        htrans_i <= 2'h2;
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(n, r, e);
    endtask
    task automatic tick(input logic [15:0] mv, input logic [15:0] ma, input logic [7:0] dis,
                        input logic [7:0] chg, input logic mid);
        @(posedge clk_i);
        meas_valid_i <= 1'b1;
        meas_i <= '{mv, mv, ma, 16'h0BA4, dis, 8'h00, chg, mid};
        @(posedge clk_i);
        meas_valid_i <= 1'b0;
        #1;
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------
    // Run
    // ------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin // Generous: whole run is about 134 cycles
            fails++;
            end_sim();
        end
    end
    initial begin
        logic [31:0] r;
        {reset_i, hsel_i, hwrite_i, meas_valid_i, haddr_i, hwdata_i, htrans_i, meas_i} = '0;
        reset_i = 1'b1;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        rdc("full reset", OFS_FULL, 32'h0);
        rdc("unmapped", 8'h3C, 32'h0);
        for (int i = 0; i < 10; i++) bus(1'b1, ca[i], cd[i], r);
        for (int i = 0; i < 10; i++) rdc("readback", ca[i], cd[i]);
        $display("test registers done");
        for (int i = 0; i < 16; i++) tick(16'hED8, 16'hFF38, 8'hFA, 8'h00, 1'b0);
        chk("learn", lv, 1'b1);
        rdc("left held", OFS_LEFT, 32'h98);
        rdc("status", OFS_PACK_STAT, 32'h11);
        tick(16'hC4E, 16'hFF38, 8'h0A, 8'h00, 1'b0);
        chk("high flag", edv_flags_o, 3'b100);
        chk("nv data", nv_data_o, 16'hDB8);
        @(posedge clk_i);
        #1;
        chk("stored", {writes, stored}, {8'h01, 16'hDB8});
        rdc("full new", OFS_FULL, 32'hDB8);
        $display("test learn done");
        tick(16'h1068, 16'h01F4, 8'h00, 8'h0A, 1'b0);
        chk("charge flags", {lv, edv_flags_o}, 4'h0);
        bus(1'b1, OFS_CONFIG, 32'h20, r);
        bus(1'b1, OFS_LEFT, 32'hD86, r);
        tick(16'hED8, 16'hFF38, 8'h0A, 8'h00, 1'b0);
        chk("restart", lv, 1'b1);
        rdc("trim", OFS_TALLY, 32'h17);
        tick(16'hED8, 16'hFF38, 8'h0A, 8'h00, 1'b1);
        chk("midrange", lv, 1'b0);
        $display("test disqualify done");
        tick(16'hB54, 16'hFFCE, 8'h01, 8'h00, 1'b0);
        chk("low rate", edv_flags_o, 3'b000);
        tick(16'hB54, 16'hEC78, 8'h0A, 8'h00, 1'b0);
        chk("overload", edv_flags_o, 3'b000);
        tick(16'hB54, 16'hFF38, 8'h0A, 8'h00, 1'b0);
        chk("all flags", edv_flags_o, 3'b111);
        $display("test thresholds done");
        end_sim();
    end
endmodule
bind capacity_learning_eod_logic capacity_learning_eod_logic_properties u_capacity_learning_eod_logic_properties (
    .clk_i, .reset_i, .hreadyout_o, .hresp_o, .meas_valid_i, .meas_i, .nv_write_o, .nv_data_o,
    .learning_valid_flag_o, .edv_flags_o);
